/* hw/usbe_pkg.sv */
// Register map and field positions of the USB error, status and control block.
// Assumes a 32-bit AXI4-Lite register bus; each register is one aligned word.
package usbe_pkg;
  localparam logic [7:0] OFF_ERR_FLAGS = 8'h00;
  localparam logic [7:0] OFF_ERR_EN = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CONTROL = 8'h0C;
  localparam logic [7:0] OFF_INT_FLAGS = 8'h10;
  localparam logic [7:0] OFF_INT_EN = 8'h14;
  // Error flag positions
  localparam int unsigned EB_PID = 0;
  localparam int unsigned EB_CRC5_EOF = 1;
  localparam int unsigned EB_CRC16 = 2;
  localparam int unsigned EB_DFN8 = 3;
  localparam int unsigned EB_TURN = 4;
  localparam int unsigned EB_DMA = 5;
  localparam int unsigned EB_BMX = 6;
  localparam int unsigned EB_STUFF = 7;
  // Interrupt flag and enable positions
  localparam int unsigned IB_SUMMARY = 1;
  localparam int unsigned IB_TOKEN = 3;
  // Control positions
  localparam int unsigned CB_EN = 0;
  localparam int unsigned CB_PPB = 1;
  localparam int unsigned CB_RESUME = 2;
  localparam int unsigned CB_HOST = 3;
  localparam int unsigned CB_RST = 4;
  localparam int unsigned CB_PKT = 5;
  // Status field position (bank bit at 2, direction 3, endpoint 7:4)
  localparam int unsigned SB_LOW = 2;
  // Idle bit-times after end-of-packet that are still legal
  localparam logic [4:0] TURN_BITS = 5'h10;
  localparam int unsigned QUEUE_DEPTH = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* hw/usbe_top.sv */
// USB error flags, error enables, transfer status queue and control register.
// Assumes link events are one-cycle pulses synchronous to aclk and that
// bit_tick pulses once per bus bit-time.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
// Operation
// [RL1] Device mode: CRC5 token failure sets bit 1
// [RL2] Host mode: bit 1 flags end-of-frame error
// [RL3] PID check failure sets bit 0
// [RL4] Late grant or truncation sets DMA flag
// [RL5] Over 16 idle bit-times flags turnaround
// [RL6] One enable per flag, reset zero
// [RL7] Enable 1 gates CRC5 or EOF flag
// [RL8] Summary enable gates shared interrupt request
// [RL9] Status 7:4 give last endpoint number
// [RL10] Status bit 3 is transmit direction
// [RL11] Status bit 2 is odd bank
// [RL12] Status shows head of four-entry queue
// [RL13] Clearing token-complete pops the queue
// [RL14] Control 7:6 show live J and SE0
// [RL15] Device: bit 5 disables, set by SETUP
// [RL16] Host: bit 5 shows token in progress
// [RL17] Software checks busy before next token
// [RL18] Host: bit 4 drives bus reset
// [RL19] Bit 3 enables host; change resets host
// [RL20] Software holds resume 10 or 25 ms
// [RL21] Host: resume clear appends low-speed EOP
// [RL22] Bits 31:8 read zero, ignore writes
// [RL23] Flags set by hardware, write one clears
// [RL24] Only enabled errors set summary flag
// [RL25] Queue in order; flag resets per entry
module usbe_top #(
  parameter int unsigned DEPTH = usbe_pkg::QUEUE_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pid_fail_evt,
  input wire logic crc5_fail_evt,
  input wire logic crc16_fail_evt,
  input wire logic data_size_evt,
  input wire logic bit_stuff_evt,
  input wire logic bus_matrix_evt,
  input wire logic dma_late_evt,
  input wire logic buffer_trunc_evt,
  input wire logic link_busy,
  input wire logic sof_count_zero,
  input wire logic bit_tick,
  input wire logic eop_seen,
  input wire logic packet_start,
  input wire logic xfer_done,
  input wire logic [3:0] xfer_endpoint,
  input wire logic xfer_tx,
  input wire logic xfer_odd,
  input wire logic line_j,
  input wire logic line_se0,
  input wire logic setup_token_rcvd,
  input wire logic token_executing,
  output logic usb_shared_interrupt_request,
  output logic packet_processing_disable,
  output logic bus_reset_drive,
  output logic host_capability_enable,
  output logic host_logic_reset,
  output logic resume_drive,
  output logic low_speed_eop_req,
  output logic ppb_reset,
  output logic module_enable
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
    $error("DEPTH must be a power of two, at least 2");
  end

  // Register index from a byte address; 7 marks an unmapped address
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    unique case (addr)
      usbe_pkg::OFF_ERR_FLAGS: reg_index = 3'h0;
      usbe_pkg::OFF_ERR_EN: reg_index = 3'h1;
      usbe_pkg::OFF_STATUS: reg_index = 3'h2;
      usbe_pkg::OFF_CONTROL: reg_index = 3'h3;
      usbe_pkg::OFF_INT_FLAGS: reg_index = 3'h4;
      usbe_pkg::OFF_INT_EN: reg_index = 3'h5;
      default: reg_index = 3'h7;
    endcase
  endfunction

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = p + PW'(1);
  endfunction

  logic [7:0] err_flags, err_en, ctl, int_en;
  logic summary_flag;
  logic [5:0] queue [DEPTH];
  logic [PW-1:0] rd_ptr, wr_ptr;
  logic [CW-1:0] q_count;
  logic [4:0] idle_bits;
  logic turn_armed, aw_full, w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  logic host, token_complete, turn_timeout, wr_fire, wr_lane0, push, pop;
  logic [2:0] wr_idx;
  logic [7:0] err_evt, wr_byte, status_byte, ctl_read, int_read, next_rbyte;

  assign host = ctl[usbe_pkg::CB_HOST];
  assign token_complete = (q_count != '0);

  // Bus write handshake: address and data latch independently
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_full && w_full && !s_axi_bvalid;
  assign wr_idx = reg_index(aw_addr);
  // Only the low byte lane holds implemented bits
  assign wr_lane0 = wr_fire && w_strb[0];
  assign wr_byte = w_data[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= usbe_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_idx == 3'h7) ? usbe_pkg::RESP_SLVERR : usbe_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Turnaround watchdog: the 17th idle bit-time after EOP times out
  // [RL5] idle bit count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_bits <= 5'h00;
      turn_armed <= 1'b0;
    end else if (eop_seen) begin
      idle_bits <= 5'h00;
      turn_armed <= 1'b1;
    end else if (packet_start || host_logic_reset) begin
      turn_armed <= 1'b0;
    end else if (turn_armed && bit_tick) begin
      if (idle_bits == usbe_pkg::TURN_BITS) begin
        turn_armed <= 1'b0;
      end else begin
        idle_bits <= idle_bits + 5'h01;
      end
    end
  end
  assign turn_timeout = turn_armed && bit_tick && !eop_seen && !packet_start
    && (idle_bits == usbe_pkg::TURN_BITS);

  // Error conditions, one per flag position
  always_comb begin
    err_evt = 8'h00;
    // [RL3] PID check failure
    err_evt[usbe_pkg::EB_PID] = pid_fail_evt;
    // [RL1] [RL2] CRC5 in device, EOF in host
    err_evt[usbe_pkg::EB_CRC5_EOF] = host ? (link_busy && sof_count_zero) : crc5_fail_evt;
    err_evt[usbe_pkg::EB_CRC16] = crc16_fail_evt;
    err_evt[usbe_pkg::EB_DFN8] = data_size_evt;
    err_evt[usbe_pkg::EB_TURN] = turn_timeout;
    // [RL4] late grant or truncated packet
    err_evt[usbe_pkg::EB_DMA] = dma_late_evt || buffer_trunc_evt;
    err_evt[usbe_pkg::EB_BMX] = bus_matrix_evt;
    err_evt[usbe_pkg::EB_STUFF] = bit_stuff_evt;
  end

  // Sticky error flags; a new event beats a same-cycle clear
  // [RL23] write one clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_flags <= usbe_pkg::RST_BYTE;
    end else if (wr_lane0 && wr_idx == 3'h0) begin
      err_flags <= (err_flags & ~wr_byte) | err_evt;
    end else begin
      err_flags <= err_flags | err_evt;
    end
  end

  // [RL6] error enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_en <= usbe_pkg::RST_BYTE;
    end else if (wr_lane0 && wr_idx == 3'h1) begin
      err_en <= wr_byte;
    end
  end

  // Summary error flag: only enabled conditions raise it
  // [RL24] [RL7] enable gating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      summary_flag <= 1'b0;
    end else if ((err_evt & err_en) != 8'h00) begin
      summary_flag <= 1'b1;
    end else if (wr_lane0 && wr_idx == 3'h4 && wr_byte[usbe_pkg::IB_SUMMARY]) begin
      summary_flag <= 1'b0;
    end
  end

  // Interrupt enables; only summary and token-complete exist here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_en <= usbe_pkg::RST_BYTE;
    end else if (wr_lane0 && wr_idx == 3'h5) begin
      int_en <= wr_byte & 8'h0A;
    end
  end

  // [RL8] summary enable gates errors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_shared_interrupt_request <= 1'b0;
    end else begin
      usb_shared_interrupt_request <= (summary_flag && int_en[usbe_pkg::IB_SUMMARY])
        || (token_complete && int_en[usbe_pkg::IB_TOKEN]);
    end
  end

  // Status queue; a push into a full queue is dropped unless a pop comes in the same cycle
  // [RL13] clearing token-complete pops
  assign pop = wr_lane0 && wr_idx == 3'h4 && wr_byte[usbe_pkg::IB_TOKEN] && token_complete;
  assign push = xfer_done && (q_count != CW'(DEPTH) || pop);

  // [RL12] [RL25] in-order queue
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      q_count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      if (push && !pop) begin
        q_count <= q_count + CW'(1);
      end else if (pop && !push) begin
        q_count <= q_count - CW'(1);
      end
    end
  end

  // [RL9] [RL10] [RL11] status entry
  always_ff @(posedge aclk) begin
    if (push) begin
      queue[wr_ptr] <= {xfer_endpoint, xfer_tx, xfer_odd};
    end
  end
  assign status_byte = {queue[rd_ptr], 2'b00};

  // Control register; bit 5 in host mode is the busy indicator
  // [RL15] [RL19] control bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl <= usbe_pkg::RST_BYTE;
    end else begin
      if (wr_lane0 && wr_idx == 3'h3) begin
        ctl[usbe_pkg::CB_RST:usbe_pkg::CB_EN] <= wr_byte[usbe_pkg::CB_RST:usbe_pkg::CB_EN];
        if (!host) begin
          ctl[usbe_pkg::CB_PKT] <= wr_byte[usbe_pkg::CB_PKT];
        end
      end
      if (!host && setup_token_rcvd) begin
        ctl[usbe_pkg::CB_PKT] <= 1'b1;
      end
    end
  end

  // Host reset pulse on any change of host enable; EOP after host resume
  // [RL19] [RL21] write side effects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_logic_reset <= 1'b0;
      low_speed_eop_req <= 1'b0;
    end else begin
      host_logic_reset <= wr_lane0 && wr_idx == 3'h3
        && (wr_byte[usbe_pkg::CB_HOST] != host);
      low_speed_eop_req <= wr_lane0 && wr_idx == 3'h3 && host
        && ctl[usbe_pkg::CB_RESUME] && !wr_byte[usbe_pkg::CB_RESUME];
    end
  end

  // [RL18] host bus reset
  assign bus_reset_drive = ctl[usbe_pkg::CB_RST] && host;
  assign packet_processing_disable = ctl[usbe_pkg::CB_PKT] && !host;
  assign host_capability_enable = host;
  assign resume_drive = ctl[usbe_pkg::CB_RESUME];
  assign ppb_reset = ctl[usbe_pkg::CB_PPB];
  assign module_enable = ctl[usbe_pkg::CB_EN];

  // [RL14] [RL16] live bits on read
  assign ctl_read = {line_j, line_se0,
    host ? token_executing : ctl[usbe_pkg::CB_PKT], ctl[usbe_pkg::CB_RST:usbe_pkg::CB_EN]};
  assign int_read = {4'h0, token_complete, 1'b0, summary_flag, 1'b0};

  always_comb begin
    unique case (reg_index(s_axi_araddr))
      3'h0: next_rbyte = err_flags;
      3'h1: next_rbyte = err_en;
      3'h2: next_rbyte = status_byte;
      3'h3: next_rbyte = ctl_read;
      3'h4: next_rbyte = int_read;
      3'h5: next_rbyte = int_en;
      default: next_rbyte = 8'h00;
    endcase
  end

  // Read answer one cycle after the address is taken
  // [RL22] upper bits zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= usbe_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, next_rbyte};
      s_axi_rresp <= (reg_index(s_axi_araddr) == 3'h7)
        ? usbe_pkg::RESP_SLVERR : usbe_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  a_pid_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [RL3]
    pid_fail_evt |=> err_flags[0]) else $error("PID flag not set");
  a_crc5_dev: assert property (@(posedge aclk) disable iff (!aresetn) // [RL1]
    !host && crc5_fail_evt |=> err_flags[1]) else $error("CRC5 flag not set");
  a_eof_host: assert property (@(posedge aclk) disable iff (!aresetn) // [RL2]
    host && link_busy && sof_count_zero |=> err_flags[1]) else $error("EOF flag not set");
  a_dma_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [RL4]
    buffer_trunc_evt || dma_late_evt |=> err_flags[5]) else $error("DMA flag not set");
  a_turn_wait: assert property (@(posedge aclk) disable iff (!aresetn) // [RL5]
    $rose(err_flags[4]) |-> $past(idle_bits) == 5'h10) else $error("Turnaround too early");
  a_summary_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [RL24]
    $rose(summary_flag) |-> ($past(err_evt) & $past(err_en)) != 8'h00)
    else $error("Summary set by masked error");
  a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [RL8]
    usb_shared_interrupt_request |-> $past(int_en[1]) || $past(int_en[3]))
    else $error("Interrupt without enable");
  a_pop_clear: assert property (@(posedge aclk) disable iff (!aresetn) // [RL13]
    pop && !push |=> q_count == $past(q_count) - CW'(1)) else $error("Queue not popped");
  a_setup_dis: assert property (@(posedge aclk) disable iff (!aresetn) // [RL15]
    !host && setup_token_rcvd |=> packet_processing_disable) else $error("SETUP not latched");
  a_host_reset: assert property (@(posedge aclk) disable iff (!aresetn) // [RL19]
    host != $past(host) |-> host_logic_reset) else $error("No host reset on toggle");
  a_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [RL22]
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("Upper bits not zero");
endmodule

/* test/usbe_link_model.sv */
// Link-side partner: the USB host or peripheral that causes bus events.
// Assumes aclk is the block clock; every event is a one-cycle pulse.
`timescale 1ns/1ns
module usbe_link_model (
  input wire logic aclk,
  output logic [8:0] evt,
  output logic bit_tick,
  output logic eop_seen,
  output logic packet_start,
  output logic xfer_done,
  output logic [3:0] xfer_endpoint,
  output logic xfer_tx,
  output logic xfer_odd,
  output logic line_j,
  output logic line_se0,
  output logic token_executing,
  output logic link_busy,
  output logic sof_count_zero
);
  // Quiet bus at start: idle shows a J state
  initial begin
    {evt, bit_tick, eop_seen, packet_start, xfer_done} = '0;
    {xfer_endpoint, xfer_tx, xfer_odd} = '0;
    {line_j, line_se0, token_executing, link_busy, sof_count_zero} = 5'b10000;
  end

  // One-cycle event on line i (line 4 is a received SETUP token)
  task automatic pulse(input int i);
    evt <= 9'h001 << i;
    @(posedge aclk);
    evt <= 9'h000;
    @(posedge aclk);
  endtask

  // End of packet, n idle bit-times, then a new packet disarms the timer
  task automatic turn(input int n);
    eop_seen <= 1'b1;
    @(posedge aclk);
    eop_seen <= 1'b0;
    repeat (n) begin
      bit_tick <= 1'b1;
      @(posedge aclk);
      bit_tick <= 1'b0;
      @(posedge aclk);
    end
    packet_start <= 1'b1;
    @(posedge aclk);
    packet_start <= 1'b0;
    @(posedge aclk);
  endtask

  // Finished transfer; fields go stale (inverted) once the strobe drops
  task automatic xfer(input logic [3:0] ep, input logic tx, input logic odd);
    {xfer_endpoint, xfer_tx, xfer_odd} <= {ep, tx, odd};
    xfer_done <= 1'b1;
    @(posedge aclk);
    xfer_done <= 1'b0;
    {xfer_endpoint, xfer_tx, xfer_odd} <= ~{ep, tx, odd};
    @(posedge aclk);
  endtask

  // Live levels: J, SE0, token running, link busy, frame counter at zero
  task automatic lines(input logic [4:0] v);
    {line_j, line_se0, token_executing, link_busy, sof_count_zero} <= v;
    @(posedge aclk);
  endtask
endmodule

/* test/usbe_top_bench.sv */
// Self-checking bench for the USB error, status and control block.
// Assumes an AXI4-Lite master here and the link partner model beside it.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module usbe_top_bench;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, xfer_endpoint;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [8:0] evt;
  logic bit_tick, eop_seen, packet_start, xfer_done, xfer_tx, xfer_odd, line_j, line_se0;
  logic token_executing, link_busy, sof_count_zero, usb_shared_interrupt_request;
  logic packet_processing_disable, bus_reset_drive, host_capability_enable, host_logic_reset;
  logic resume_drive, low_speed_eop_req, ppb_reset, module_enable;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_hr = 0;
  int n_ls = 0;

  usbe_top dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pid_fail_evt(evt[0]), .crc5_fail_evt(evt[1]),
    .crc16_fail_evt(evt[2]), .data_size_evt(evt[3]), .dma_late_evt(evt[5]),
    .bus_matrix_evt(evt[6]), .bit_stuff_evt(evt[7]), .buffer_trunc_evt(evt[8]),
    .link_busy, .sof_count_zero, .bit_tick, .eop_seen, .packet_start, .xfer_done,
    .xfer_endpoint, .xfer_tx, .xfer_odd, .line_j, .line_se0, .setup_token_rcvd(evt[4]),
    .token_executing, .usb_shared_interrupt_request, .packet_processing_disable,
    .bus_reset_drive, .host_capability_enable, .host_logic_reset, .resume_drive,
    .low_speed_eop_req, .ppb_reset, .module_enable
  );

  usbe_link_model link (
    .aclk, .evt, .bit_tick, .eop_seen, .packet_start, .xfer_done, .xfer_endpoint,
    .xfer_tx, .xfer_odd, .line_j, .line_se0, .token_executing, .link_busy, .sof_count_zero
  );

  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Count one-cycle control pulses at the falling edge, clear of the checks
  always @(negedge aclk) begin
    if (host_logic_reset === 1'b1) n_hr++;
    if (low_speed_eop_req === 1'b1) n_ls++;
  end

  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Bus write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    `CHK("bresp", r, s_axi_bresp)
    if (n == 40) begin
      n_mismatch++;
      test_done();
    end
  endtask

  // Bus read compared with the expected word and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    `CHK($sformatf("rdata at %h", a), e, s_axi_rdata)
    `CHK("rresp", r, s_axi_rresp)
    if (n == 40) begin
      n_mismatch++;
      test_done();
    end
  endtask

  task automatic t_reset();
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h0C, 32'h80);
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0, 2'h2);
    wr(8'h18, 32'hFF, 2'h2);
    // Lane 0 strobe low: the write is ignored but still answered
    s_axi_wstrb <= 4'hE;
    wr(8'h04, 32'hFF);
    s_axi_wstrb <= 4'hF;
    rd(8'h04, 32'h0);
  endtask

  // Every error line, its flag, write-zero, write-one clear and interrupt path
  task automatic t_errors();
    int i;
    wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h04, 32'hFF);
    wr(8'h14, 32'h2);
    for (i = 0; i < 9; i++) begin
      if (i == 4) continue;
      link.pulse(i);
      rd(8'h00, 32'h1 << (i == 8 ? 5 : i));
      `CHK("irq", 1'b1, usb_shared_interrupt_request)
      wr(8'h00, 32'h0);
      rd(8'h00, 32'h1 << (i == 8 ? 5 : i));
      wr(8'h00, 32'hFF);
      rd(8'h00, 32'h0);
      wr(8'h10, 32'h2);
    end
    wr(8'h04, 32'hFD);
    link.pulse(1);
    rd(8'h10, 32'h0);
    wr(8'h00, 32'hFF);
    wr(8'h14, 32'h0);
    link.pulse(0);
    rd(8'h10, 32'h2);
    `CHK("irq", 1'b0, usb_shared_interrupt_request)
    wr(8'h10, 32'h2);
    wr(8'h00, 32'hFF);
    wr(8'h04, 32'h0);
  endtask

  // Exactly 16 idle bit-times are legal, the 17th is a time-out
  task automatic t_turn();
    link.turn(16);
    rd(8'h00, 32'h0);
    link.turn(17);
    rd(8'h00, 32'h10);
    wr(8'h00, 32'hFF);
  endtask

  // Five transfers into a four-deep queue, popped in order
  task automatic t_queue();
    logic [31:0] q [4] = '{32'hF8, 32'h04, 32'hAC, 32'h50};
    int i;
    link.xfer(4'hF, 1'b1, 1'b0);
    link.xfer(4'h0, 1'b0, 1'b1);
    link.xfer(4'hA, 1'b1, 1'b1);
    link.xfer(4'h5, 1'b0, 1'b0);
    link.xfer(4'h3, 1'b1, 1'b1);
    for (i = 0; i < 4; i++) begin
      rd(8'h10, 32'h8);
      rd(8'h08, q[i]);
      wr(8'h10, 32'h8);
    end
    rd(8'h10, 32'h0);
  endtask

  // Live lines, SETUP lock, host enable, token busy, bus reset, EOF, resume end
  task automatic t_control();
    link.lines(5'b01000);
    rd(8'h0C, 32'h40);
    link.lines(5'b10000);
    link.pulse(4);
    rd(8'h0C, 32'hA0);
    `CHK("pkt_dis", 1'b1, packet_processing_disable)
    wr(8'h0C, 32'h08);
    `CHK("host_rst", 1, n_hr)
    `CHK("host_en", 1'b1, host_capability_enable)
    link.lines(5'b10100);
    rd(8'h0C, 32'hA8);
    link.lines(5'b10000);
    rd(8'h0C, 32'h88);
    wr(8'h0C, 32'h18);
    `CHK("bus_rst", 1'b1, bus_reset_drive)
    wr(8'h0C, 32'h08);
    `CHK("bus_rst", 1'b0, bus_reset_drive)
    link.lines(5'b10011);
    link.lines(5'b10000);
    rd(8'h00, 32'h2);
    rd(8'h10, 32'h0);
    wr(8'h04, 32'h02);
    link.lines(5'b10011);
    link.lines(5'b10000);
    rd(8'h10, 32'h2);
    wr(8'h10, 32'h2);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'hFF);
    // resume hold is software's; the block does not time it, so kept short
    wr(8'h0C, 32'h0C);
    repeat (8) @(posedge aclk);
    `CHK("resume", 1'b1, resume_drive)
    wr(8'h0C, 32'h08);
    rd(8'h0C, 32'h88);
    `CHK("ls_eop", 1, n_ls)
    wr(8'h0C, 32'h00);
    `CHK("host_rst", 2, n_hr)
    wr(8'h0C, 32'hFFFF_FF03);
    `CHK("ppb_rst", 1'b1, ppb_reset)
    `CHK("usb_en", 1'b1, module_enable)
    rd(8'h0C, 32'h83);
  endtask

  // Reset for four cycles, then each scenario in turn
  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_errors();
    t_turn();
    t_queue();
    t_control();
    test_done();
  end
endmodule
